// ---- dps_map.vh ----
// dps_map.vh: constants for the memory port pin driver and strap decoder
// assumes: included by the design file by bare name; no other contents
`ifndef DPS_MAP_VH
`define DPS_MAP_VH
// memory type codes
`define DPS_MT_SDRAM 2'h0
`define DPS_MT_RSVD 2'h1
`define DPS_MT_DDR 2'h2
`define DPS_MT_DDR2 2'h3
// memory clock codes
`define DPS_MC_100 2'h0
`define DPS_MC_133 2'h1
`define DPS_MC_166 2'h2
`define DPS_MC_200 2'h3
// cpu clock codes
`define DPS_CC_BYPASS 3'h0
`define DPS_CC_EQUAL 3'h1
`define DPS_CC_300 3'h4
// strap field positions on the address bus
`define DPS_STRAP_ADDROPT 1
`define DPS_STRAP_PLLTEST 3
`define DPS_STRAP_MCLK_LO 4
`define DPS_STRAP_CCLK_LO 5
`define DPS_STRAP_CCLK_HI 7
`define DPS_STRAP_JTAG 8
`define DPS_STRAP_MCLK_HI 10
// strap defaults (reset values of the decoded settings)
`define DPS_RST_MTYPE 2'h3
`define DPS_RST_MCLK 2'h1
`define DPS_RST_CCLK 3'h4
`define DPS_RST_ADDROPT 1'h1
`define DPS_RST_PLLTEST 1'h0
`define DPS_RST_JTAG 1'h1
// cycles that the strap inputs must agree before release (at 8 ns)
`define DPS_STRAP_SETTLE_NS 64
`define DPS_STRAP_SETTLE_CYC 8
`endif

// ---- dps_port.v ----
// dps_port.v: memory-side pin driver and reset-time strap decoder
// assumes: core_clk at 125 MHz; the memory command sequencer sits upstream on core_clk;
// strap pins and power_ok_in come from outside and are sampled through three flops
`timescale 1ns/100ps
`include "dps_map.vh"

module dps_port #(
	parameter AW = 14,
	parameter DW = 16,
	parameter SETTLE = `DPS_STRAP_SETTLE_CYC
) (
	// clock and reset
	input wire core_clk,
	input wire arst_n,
	input wire power_ok_in,
	// memory clock request from the sequencer, one bit per phase
	input wire cmd_clk_phase,
	// command from the sequencer, active high
	input wire cmd_row,
	input wire cmd_col,
	input wire cmd_write,
	input wire [1:0] cmd_cs,
	input wire [AW-1:0] cmd_addr,
	input wire [2:0] cmd_bank,
	input wire [1:0] cmd_byte_mask,
	input wire cmd_drive_data,
	input wire [DW-1:0] cmd_wdata,
	input wire cmd_dqs_level,
	// read data toward the sequencer
	output wire [DW-1:0] rd_data,
	output wire [1:0] rd_strobe,
	// memory pins
	output wire mem_clk_p,
	output wire mem_clk_n,
	output wire ras_n,
	output wire cas_n,
	output wire we_n,
	output wire [1:0] cs_n,
	output wire [1:0] dqm,
	input wire [1:0] dqs_i,
	output wire [1:0] dqs_o,
	output wire [1:0] dqs_oe,
	input wire [DW-1:0] mem_data_bus_i,
	output wire [DW-1:0] mem_data_bus_o,
	output wire mem_data_bus_oe,
	input wire [AW-1:0] mem_addr_bus_i,
	output wire [AW-1:0] mem_addr_bus_o,
	output wire mem_addr_bus_oe,
	input wire [2:0] bank_addr_i,
	output wire [2:0] bank_addr_o,
	output wire bank_addr_oe,
	// decoded settings
	output wire [1:0] mem_type,
	output wire [1:0] mem_clk_sel,
	output wire [2:0] cpu_clk_sel,
	output wire cpu_mem_clk_equal,
	output wire gpio_port_two,
	output wire pll_test_en,
	output wire jtag_en,
	output wire sys_rst_n,
	output wire pins_ready
);

	localparam ST_RESET = 3'b001;
	localparam ST_SETTLE = 3'b010;
	localparam ST_RUN = 3'b100;

	// reset sequence states, one hot:
	//   ST_RESET  power not yet good; pins idle and released, straps tracked
	//   ST_SETTLE power good; straps must hold steady for SETTLE cycles
	//   ST_RUN    settings frozen; address and bank pins driven as memory pins
	// a power loss in any state returns to ST_RESET, which releases the pins
	// again so the strap resistors show and are sampled afresh
	// hazards:
	//   the strap pins double as address outputs, so the decode must be frozen
	//   before the drivers turn on, else the design would read its own address
	//   the settle counter restarts on any strap change, so a slow pull-up that
	//   is still charging cannot be latched half way
	//   nothing here times memory commands; the upstream sequencer owns that

	// ==========================================================
	// input synchronisers
	// ==========================================================
	reg [2:0] pg_sync_ff;
	reg pg_lvl_ff;
	reg [AW-1:0] a_s1_ff, a_s2_ff, a_s3_ff;
	reg [2:0] b_s1_ff, b_s2_ff, b_s3_ff;
	wire pg_ok;

	// power good through three flops
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pg_sync_ff <= 3'h0;
		end else begin
			pg_sync_ff <= {pg_sync_ff[1:0], power_ok_in};
		end
	end

	// filtered power good level: a change counts only once the last two flops agree,
	// so a single-cycle glitch on the supply monitor never restarts the strap sequence
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pg_lvl_ff <= 1'b0;
		end else if (pg_sync_ff[1] == pg_sync_ff[2]) begin
			pg_lvl_ff <= pg_sync_ff[2];
		end
	end
	assign pg_ok = pg_lvl_ff;

	// the strap levels pass three flops like power good; the decode reads the
	// third flop and the settle counter compares the second with the third,
	// so a level is only used once two flops agree on it
	// strap levels through three flops
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			a_s1_ff <= {AW{1'b0}};
			a_s2_ff <= {AW{1'b0}};
			a_s3_ff <= {AW{1'b0}};
			b_s1_ff <= 3'h0;
			b_s2_ff <= 3'h0;
			b_s3_ff <= 3'h0;
		end else begin
			a_s1_ff <= mem_addr_bus_i;
			a_s2_ff <= a_s1_ff;
			a_s3_ff <= a_s2_ff;
			b_s1_ff <= bank_addr_i;
			b_s2_ff <= b_s1_ff;
			b_s3_ff <= b_s2_ff;
		end
	end

	// ==========================================================
	// reset sequence and strap capture
	// ==========================================================
	reg [2:0] state_ff, nxt_state;
	reg [7:0] cnt_ff;
	reg [1:0] mtype_ff;
	reg [1:0] mclk_ff;
	reg [2:0] cclk_ff;
	reg addropt_ff, plltest_ff, jtag_ff;
	reg cceq_ff;
	reg sysrst_n_ff, ready_ff;
	wire straps_stable;

	assign straps_stable = (a_s2_ff == a_s3_ff) && (b_s2_ff[1:0] == b_s3_ff[1:0]);

	// next state: wait for power good, then settle straps, then release
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RESET: begin
				if (pg_ok) begin
					nxt_state = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (!pg_ok) begin
					nxt_state = ST_RESET;
				end else if (cnt_ff == SETTLE[7:0] - 8'h01) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!pg_ok) begin
					nxt_state = ST_RESET;
				end
			end
			default: begin
				nxt_state = ST_RESET;
			end
		endcase
	end

	// state, settle counter and latched settings
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_RESET;
			cnt_ff <= 8'h00;
			mtype_ff <= `DPS_RST_MTYPE;
			mclk_ff <= `DPS_RST_MCLK;
			cclk_ff <= `DPS_RST_CCLK;
			addropt_ff <= `DPS_RST_ADDROPT;
			plltest_ff <= `DPS_RST_PLLTEST;
			jtag_ff <= `DPS_RST_JTAG;
			cceq_ff <= 1'b0; // default cpu code is not the equal code
			sysrst_n_ff <= 1'b0;
			ready_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			sysrst_n_ff <= (nxt_state == ST_RUN);
			ready_ff <= (nxt_state == ST_RUN);
			if (state_ff == ST_SETTLE && straps_stable) begin
				cnt_ff <= cnt_ff + 8'h01;
			end else begin
				cnt_ff <= 8'h00;
			end
			// capture only while pins are released; held in run
			if (state_ff != ST_RUN) begin
				mtype_ff <= b_s3_ff[1:0];
				mclk_ff <= {a_s3_ff[`DPS_STRAP_MCLK_HI], a_s3_ff[`DPS_STRAP_MCLK_LO]};
				cclk_ff <= a_s3_ff[`DPS_STRAP_CCLK_HI:`DPS_STRAP_CCLK_LO];
				cceq_ff <= (a_s3_ff[`DPS_STRAP_CCLK_HI:`DPS_STRAP_CCLK_LO] == `DPS_CC_EQUAL);
				addropt_ff <= a_s3_ff[`DPS_STRAP_ADDROPT];
				plltest_ff <= a_s3_ff[`DPS_STRAP_PLLTEST];
				jtag_ff <= a_s3_ff[`DPS_STRAP_JTAG];
			end
		end
	end

	// ==========================================================
	// memory pin drivers
	// ==========================================================
	reg clkp_ff, clkn_ff;
	reg ras_n_ff, cas_n_ff, we_n_ff;
	reg [1:0] cs_n_ff, dqm_ff, dqs_o_ff, dqs_oe_ff, rd_strb_ff;
	reg [DW-1:0] wd_ff, rd_ff;
	reg wd_oe_ff, a_oe_ff;
	reg [AW-1:0] addr_ff;
	reg [2:0] bank_ff;
	wire run;
	wire ddr_mode;

	assign run = (state_ff == ST_RUN);
	assign ddr_mode = mtype_ff[1];

	// every pin is registered so the memory sees clean edges one core cycle
	// after the sequencer asks; the sequencer accounts for that fixed latency
	// outside run every strobe and select is forced inactive and the masks high,
	// so a memory that is still powering up never sees a stray command
	// the second select is held off in ddr2 mode whatever the sequencer asks,
	// because only the first select reaches a ddr2 device
	// data strobes are driven only in the double data rate types; in sdram mode
	// the strobe pins stay released and the captured strobe reads as zero
	// the memory clock pair is built from the sequencer's phase request, so its
	// rate is whatever the sequencer toggles; both halves come from flops
	// the address and bank drivers share one enable, raised only in run, so the
	// strap resistors are never fought while the settings are being sampled
	// write data and its enable move together; the data flop runs freely but
	// is only seen on the pins while the enable stands

	// registered command and data pins; idle values outside run
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			clkp_ff <= 1'b0;
			clkn_ff <= 1'b1;
			ras_n_ff <= 1'b1;
			cas_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
			cs_n_ff <= 2'h3;
			dqm_ff <= 2'h3;
			dqs_o_ff <= 2'h0;
			dqs_oe_ff <= 2'h0;
			wd_ff <= {DW{1'b0}};
			wd_oe_ff <= 1'b0;
			addr_ff <= {AW{1'b0}};
			bank_ff <= 3'h0;
			a_oe_ff <= 1'b0;
			rd_ff <= {DW{1'b0}};
			rd_strb_ff <= 2'h0;
		end else begin
			clkp_ff <= run & cmd_clk_phase;
			clkn_ff <= ~(run & cmd_clk_phase);
			ras_n_ff <= ~(run & cmd_row);
			cas_n_ff <= ~(run & cmd_col);
			we_n_ff <= ~(run & cmd_write);
			cs_n_ff[0] <= ~(run & cmd_cs[0]);
			cs_n_ff[1] <= ~(run & cmd_cs[1] & (mtype_ff != `DPS_MT_DDR2));
			dqm_ff <= run ? cmd_byte_mask : 2'h3;
			dqs_oe_ff <= {2{run & ddr_mode & cmd_drive_data}};
			dqs_o_ff <= {2{cmd_dqs_level}};
			wd_ff <= cmd_wdata;
			wd_oe_ff <= run & cmd_drive_data;
			addr_ff <= cmd_addr;
			bank_ff <= cmd_bank;
			a_oe_ff <= run;
			rd_ff <= mem_data_bus_i;
			rd_strb_ff <= ddr_mode ? dqs_i : 2'h0;
		end
	end

	// limitations:
	//   read data is taken one core cycle after the pins with no strobe
	//   alignment; a capture stage timed by the data strobe belongs upstream
	//   the equality flag is decoded at capture time and frozen with the rest
	//   of the settings, so it never glitches while the code is being sampled
	//   bank bit 2 is driven but never sampled as a strap
	// outputs straight from flops
	assign mem_clk_p = clkp_ff;
	assign mem_clk_n = clkn_ff;
	assign ras_n = ras_n_ff;
	assign cas_n = cas_n_ff;
	assign we_n = we_n_ff;
	assign cs_n = cs_n_ff;
	assign dqm = dqm_ff;
	assign dqs_o = dqs_o_ff;
	assign dqs_oe = dqs_oe_ff;
	assign mem_data_bus_o = wd_ff;
	assign mem_data_bus_oe = wd_oe_ff;
	assign mem_addr_bus_o = addr_ff;
	assign mem_addr_bus_oe = a_oe_ff;
	assign bank_addr_o = bank_ff;
	assign bank_addr_oe = a_oe_ff;
	assign rd_data = rd_ff;
	assign rd_strobe = rd_strb_ff;
	assign mem_type = mtype_ff;
	assign mem_clk_sel = mclk_ff;
	assign cpu_clk_sel = cclk_ff;
	assign cpu_mem_clk_equal = cceq_ff;
	assign gpio_port_two = addropt_ff;
	assign pll_test_en = plltest_ff;
	assign jtag_en = jtag_ff;
	assign sys_rst_n = sysrst_n_ff;
	assign pins_ready = ready_ff;

endmodule // dps_port

// ---- dps_port_asserts.sv ----
// dps_port_asserts.sv: pin timing checks for the memory port
// assumes: bound into dps_port, names match its ports
`timescale 1ns/100ps
module dps_port_asserts (
	// clock and reset
	input wire core_clk, arst_n,
	// commands
	input wire cmd_row, cmd_col, cmd_write, cmd_drive_data,
	input wire [1:0] cmd_cs,
	// pins
	input wire ras_n, cas_n, we_n, mem_clk_p, mem_clk_n, mem_data_bus_oe,
	input wire [1:0] cs_n, dqs_oe,
	// settings
	input wire [1:0] mem_type,
	input wire [2:0] cpu_clk_sel,
	input wire cpu_mem_clk_equal, pins_ready
);
	// ==========
	// run seen on two edges in a row
	reg was_run_ff;
	wire live = was_run_ff && pins_ready;
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) was_run_ff <= 1'b0;
		else was_run_ff <= pins_ready;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	chk_row_strobe: assert property (live |-> ras_n == !$past(cmd_row)) else $error("ras");
	chk_col_strobe: assert property (live |-> cas_n == !$past(cmd_col)) else $error("cas");
	chk_write_enable: assert property (live |-> we_n == !$past(cmd_write)) else $error("we");
	chk_select_zero: assert property (live |-> cs_n[0] == !$past(cmd_cs[0])) else $error("cs0");
	chk_ddr2_select: assert property (mem_type == 2'h3 |-> cs_n[1]) else $error("cs1");
	chk_strobe_ddr: assert property (|dqs_oe |-> mem_type[1]) else $error("dqs");
	chk_data_drive: assert property (live |-> mem_data_bus_oe == $past(cmd_drive_data)) else $error("oe");
	chk_clock_pair: assert property (mem_clk_p != mem_clk_n) else $error("clk");
	chk_equal_flag: assert property (cpu_mem_clk_equal == (cpu_clk_sel == 3'h1)) else $error("eq");
	chk_held_run: assert property (live |-> $stable(mem_type) && $stable(cpu_clk_sel)) else $error("held");
endmodule // dps_port_asserts
bind dps_port dps_port_asserts u_chk (.*);

// ---- dps_mem_model.sv ----
// dps_mem_model.sv: one-word memory behind the pins, plus strap resistors
// assumes: pins from dps_port, strap levels from the bench
`timescale 1ns/100ps
module dps_mem_model (
	// pins from the controller
	input wire mem_clk_p, cas_n, we_n, data_oe, addr_oe,
	input wire [1:0] cs_n, dqm,
	input wire [15:0] data_o,
	input wire [13:0] addr_o, strap_addr,
	// pins toward the controller
	output wire [15:0] data_i,
	output wire [13:0] addr_i,
	output wire [1:0] dqs_rd
);
	reg [15:0] word_ff = 16'h0000;
	reg rd_ff = 1'b0;
	// strobes driven with read data, both bytes alike
	assign dqs_rd = {2{rd_ff}};
	// strap resistors show while the controller lets go
	assign addr_i = addr_oe ? addr_o : strap_addr;
	// the controller's data while it drives, read word while reading, else the inverse so stale data never passes
	assign data_i = data_oe ? data_o : rd_ff ? word_ff : ~word_ff;
	// commands taken on the rising memory clock, first select only
	always @(posedge mem_clk_p) begin
		rd_ff <= !cs_n[0] && !cas_n && we_n;
		if (!cs_n[0] && !cas_n && !we_n) begin
			if (!dqm[0]) word_ff[7:0] <= data_o[7:0];
			if (!dqm[1]) word_ff[15:8] <= data_o[15:8];
		end
	end
endmodule // dps_mem_model

// ---- dps_port_tb_top.sv ----
// dps_port_tb_top.sv: self-checking bench for dps_port
// assumes: dps_port, dps_mem_model and the checker compiled first
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module dps_port_tb_top;
	// ==========
	// stimulus and pins
	reg core_clk = 0, arst_n = 0, power_ok_in = 0, lnk_ph = 0, cmd_clk_phase = 0;
	reg cmd_row = 0, cmd_col = 0, cmd_write = 0, cmd_drive_data = 0, cmd_dqs_level = 0;
	reg [1:0] cmd_cs = 0, cmd_byte_mask = 0;
	reg [2:0] cmd_bank = 0, strap_bank = 0, k;
	reg [13:0] cmd_addr = 0, strap_addr = 0;
	reg [15:0] cmd_wdata = 0;
	wire [15:0] rd_data, mem_data_bus_o, mem_data_bus_i;
	wire [13:0] mem_addr_bus_o, mem_addr_bus_i;
	wire [2:0] bank_addr_o, bank_addr_i, cpu_clk_sel;
	wire [1:0] cs_n, dqm, dqs_oe, mem_type, mem_clk_sel, dqs_o, rd_strobe, dqs_rd;
	wire mem_clk_p, mem_clk_n, ras_n, cas_n, we_n, mem_data_bus_oe, mem_addr_bus_oe, bank_addr_oe;
	wire cpu_mem_clk_equal, gpio_port_two, pll_test_en, jtag_en, sys_rst_n, pins_ready;
	integer n_errors = 0, checked = 0, i, n;
	// ==========
	// clocks, strap resistors on the bank pins, parts
	initial forever #4 core_clk = ~core_clk;
	initial begin
		#3;
		forever #80 lnk_ph = ~lnk_ph;
	end
	always @(posedge core_clk) cmd_clk_phase <= lnk_ph;
	assign bank_addr_i = bank_addr_oe ? bank_addr_o : strap_bank;
	dps_port i_dut (.*, .dqs_i(dqs_rd));
	dps_mem_model i_mem (.mem_clk_p, .cas_n, .we_n, .cs_n, .dqm, .data_o(mem_data_bus_o), .dqs_rd,
		.data_oe(mem_data_bus_oe), .addr_o(mem_addr_bus_o), .addr_oe(mem_addr_bus_oe), .strap_addr,
		.data_i(mem_data_bus_i), .addr_i(mem_addr_bus_i));
	// ==========
	// verdict
	task complete_run;
		begin
			$display("comparisons %0d mismatches %0d", checked, n_errors);
			if (n_errors == 0 && checked > 0) $display("Regression OK");
			else $display("Regression broken");
			$finish;
		end
	endtask
	// power cycle with straps held, then bounded wait for live pins
	task boot(input [13:0] sa, input [2:0] sb);
		begin
			@(posedge core_clk) power_ok_in <= 0;
			strap_addr <= sa;
			strap_bank <= sb;
			repeat (8) @(posedge core_clk);
			power_ok_in <= 1;
			for (n = 0; pins_ready !== 1'b1; n++) begin
				if (n == 60) begin
					n_errors++;
					complete_run;
				end
				@(posedge core_clk);
			end
			#1;
		end
	endtask
	// every strap code through a power cycle
	task t_straps;
		begin
			for (i = 0; i < 8; i++) begin
				k = i;
				boot({3'h0, k[1], 1'b0, k[0], k, k[0], k[1], 1'b0, k[2], 1'b0}, {1'b0, k[1:0]});
				`CHK({mem_type, mem_clk_sel, cpu_clk_sel}, {k[1:0], k[1:0], k})
				`CHK({cpu_mem_clk_equal, gpio_port_two, pll_test_en, jtag_en}, {k == 3'h1, k})
			end
			$display("strap table done");
		end
	endtask
	// row activate asking for both selects
	task t_walk(input [1:0] sel_n);
		begin
			@(posedge core_clk) cmd_row <= 1;
			cmd_cs <= 2'h3;
			cmd_addr <= 14'h2a5c;
			cmd_bank <= 3'h5;
			@(posedge core_clk) cmd_row <= 0;
			cmd_cs <= 2'h0;
			#1;
			`CHK({ras_n, cas_n, cs_n, mem_addr_bus_o, bank_addr_o, mem_addr_bus_oe}, {2'h1, sel_n, 14'h2a5c, 4'hb})
			$display("row walk done");
		end
	endtask
	// column write or read held across a memory clock edge
	task t_xfer(input wr, input [15:0] d, input [1:0] m, input [1:0] dq);
		begin
			@(posedge core_clk) cmd_col <= 1;
			cmd_cs <= 2'h1;
			cmd_write <= wr;
			cmd_drive_data <= wr;
			cmd_dqs_level <= wr;
			cmd_wdata <= d;
			cmd_byte_mask <= m;
			repeat (25) @(posedge core_clk);
			#1;
			`CHK({cas_n, we_n, mem_data_bus_oe, dqm, cs_n[0]}, {1'b0, !wr, wr, m, 1'b0})
			if (wr) `CHK({mem_data_bus_o, dqs_oe, dqs_o}, {d, dq, {2{wr}}})
			else `CHK({rd_data, rd_strobe}, {d, dq})
			@(posedge core_clk) cmd_col <= 0;
			cmd_write <= 0;
			cmd_dqs_level <= 0;
			cmd_drive_data <= 0;
			cmd_cs <= 2'h0;
			repeat (25) @(posedge core_clk);
			$display("transfer done");
		end
	endtask
	// ==========
	// main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		#1;
		`CHK({mem_type, mem_clk_sel, cpu_clk_sel, gpio_port_two, pll_test_en, jtag_en}, 10'h365)
		`CHK({ras_n, cas_n, we_n, cs_n, mem_clk_p, mem_clk_n, mem_addr_bus_oe, sys_rst_n}, 9'h1f4)
		repeat (5) @(posedge core_clk);
		arst_n <= 1;
		t_straps;
		boot(14'h0192, 3'h3);
		t_walk(2'h2);
		t_xfer(1, 16'ha5c3, 2'h0, 2'h3);
		t_xfer(1, 16'h5a3c, 2'h2, 2'h3);
		t_xfer(0, 16'ha53c, 2'h0, 2'h3);
		boot(14'h0192, 3'h0);
		t_walk(2'h0);
		t_xfer(1, 16'h0f0f, 2'h1, 2'h0);
		t_xfer(0, 16'h0f3c, 2'h0, 2'h0);
		complete_run;
	end
endmodule // dps_port_tb_top
